// [rtl/cxb_defines.vh]
`ifndef CXB_DEFINES_VH
`define CXB_DEFINES_VH
// ****************************************
// sizes
// ****************************************
`define CXB_CELLS 22
`define CXB_BANK 11
`define CXB_CFG_W 7
`define CXB_MODE_LSB 4
`define CXB_MODE_W 3
`define CXB_SEL_LSB 0
`define CXB_SEL_W 4
`define CXB_SIG_W 32
`define CXB_SIG_LSB 154
`define CXB_IMG_W 186
`define CXB_SUM_W 16
// ****************************************
// cell function codes
// ****************************************
`define CXB_FN_OUT 3'h0
`define CXB_FN_OUT_INV 3'h1
`define CXB_FN_LOW 3'h2
`define CXB_FN_HIGH 3'h3
`define CXB_FN_INPUT 3'h4
`define CXB_FN_OFF 3'h7
// ****************************************
// timing
// ****************************************
`define CXB_CLK_NS 10
`define CXB_ERASE_US 10_000
`define CXB_WRITE_US 10_000
`define CXB_ERASE_CYC ((`CXB_ERASE_US * 1000) / `CXB_CLK_NS)
`define CXB_WRITE_CYC ((`CXB_WRITE_US * 1000) / `CXB_CLK_NS)
`endif

// [rtl/cxb_crossbar.v]
`timescale 1ns/1ps
`include "cxb_defines.vh"
module cxb_crossbar #(
  parameter ERASE_CYC = `CXB_ERASE_CYC,
  parameter WRITE_CYC = `CXB_WRITE_CYC
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`CXB_CELLS-1:0] i_pad_in,
  output reg [`CXB_CELLS-1:0] o_pad_out,
  output reg [`CXB_CELLS-1:0] o_pad_oe,
  input wire i_prog_mode,
  input wire i_prog_sclk,
  input wire i_prog_serial_in,
  output reg o_prog_serial_out,
  output reg o_prog_busy,
  output reg [`CXB_SIG_W-1:0] o_signature,
  output reg [`CXB_SUM_W-1:0] o_checksum
);
  // ****************************************
  // state codes
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam ST_WRITE = 2'h3;
  // ****************************************
  // pad synchronisers
  // ****************************************
  reg [`CXB_CELLS-1:0] pad_s1_reg;
  reg [`CXB_CELLS-1:0] pad_s2_reg;
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pad_s1_reg <= {`CXB_CELLS{1'b0}};
      pad_s2_reg <= {`CXB_CELLS{1'b0}};
    end
    else
    begin
      pad_s1_reg <= i_pad_in;
      pad_s2_reg <= pad_s1_reg;
    end
  end
  // ****************************************
  // programming pin synchronisers
  // ****************************************
  reg [2:0] prog_s1_reg;
  reg [2:0] prog_s2_reg;
  reg sclk_d_reg;
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prog_s1_reg <= 3'h0;
      prog_s2_reg <= 3'h0;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      prog_s1_reg <= {i_prog_mode, i_prog_sclk, i_prog_serial_in};
      prog_s2_reg <= prog_s1_reg;
      sclk_d_reg <= prog_s2_reg[1];
    end
  end
  wire mode_w = prog_s2_reg[2];
  wire sclk_rise_w = prog_s2_reg[1] & ~sclk_d_reg;
  // ****************************************
  // programming state machine
  // ****************************************
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [19:0] cnt_reg;
  reg [`CXB_IMG_W-1:0] shift_reg;
  reg [`CXB_IMG_W-1:0] nv_reg;
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (mode_w)
          state_next = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (!mode_w)
          state_next = ST_ERASE;
      end
      ST_ERASE:
      begin
        if (cnt_reg == ERASE_CYC[19:0] - 20'h0_0001)
          state_next = ST_WRITE;
      end
      ST_WRITE:
      begin
        if (cnt_reg == WRITE_CYC[19:0] - 20'h0_0001)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end
  // ****************************************
  // state register, counter and shifter
  // ****************************************
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 20'h0_0000;
      shift_reg <= {`CXB_IMG_W{1'b1}};
      o_prog_serial_out <= 1'b0;
      o_prog_busy <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      o_prog_busy <= (state_next != ST_IDLE);
      if (state_next != state_reg)
        cnt_reg <= 20'h0_0000;
      else if (state_reg == ST_ERASE || state_reg == ST_WRITE)
        cnt_reg <= cnt_reg + 20'h0_0001;
      if (state_reg == ST_IDLE && mode_w)
        shift_reg <= nv_reg;
      else if (state_reg == ST_SHIFT && sclk_rise_w)
        shift_reg <= {shift_reg[`CXB_IMG_W-2:0], prog_s2_reg[0]};
      o_prog_serial_out <= shift_reg[`CXB_IMG_W-1];
    end
  end
  // ****************************************
  // non-volatile image, not cleared by reset
  // ****************************************
  always @(posedge i_mclk)
  begin
    if (state_reg == ST_ERASE)
      nv_reg <= {`CXB_IMG_W{1'b1}};
    else if (state_reg == ST_WRITE && state_next == ST_IDLE)
      nv_reg <= shift_reg;
  end
  // ****************************************
  // checksum chain, seeded with the sum of the two signature halves
  // ****************************************
  wire [`CXB_SUM_W-1:0] sum_w [0:`CXB_CELLS];
  assign sum_w[0] = nv_reg[`CXB_SIG_LSB +: 16] + nv_reg[`CXB_SIG_LSB + 16 +: 16];
  // ****************************************
  // per-cell routing
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < `CXB_CELLS; c = c + 1)
    begin : g_cell
      wire [`CXB_MODE_W-1:0] fn_w = nv_reg[c*`CXB_CFG_W + `CXB_MODE_LSB +: `CXB_MODE_W];
      wire [`CXB_SEL_W-1:0] sel_w = nv_reg[c*`CXB_CFG_W + `CXB_SEL_LSB +: `CXB_SEL_W];
      wire [`CXB_BANK-1:0] far_w;
      reg drv_w;
      reg en_w;
      if (c < `CXB_BANK)
        assign far_w = pad_s2_reg[`CXB_CELLS-1:`CXB_BANK];
      else
        assign far_w = pad_s2_reg[`CXB_BANK-1:0];
      wire src_w = (sel_w < `CXB_BANK) ? far_w[sel_w] : 1'b0;
      always @*
      begin
        drv_w = 1'b0;
        en_w = 1'b1;
        case (fn_w)
          `CXB_FN_OUT: drv_w = src_w;
          `CXB_FN_OUT_INV: drv_w = ~src_w;
          `CXB_FN_LOW: drv_w = 1'b0;
          `CXB_FN_HIGH: drv_w = 1'b1;
          `CXB_FN_INPUT: en_w = 1'b0;
          `CXB_FN_OFF: en_w = 1'b0;
          default: en_w = 1'b0;
        endcase
      end
      assign sum_w[c+1] = sum_w[c] + {9'h000, nv_reg[c*`CXB_CFG_W +: `CXB_CFG_W]};
      always @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          o_pad_out[c] <= 1'b0;
          o_pad_oe[c] <= 1'b0;
        end
        else
        begin
          o_pad_out[c] <= drv_w;
          o_pad_oe[c] <= en_w & (state_next == ST_IDLE);
        end
      end
    end
  endgenerate
  // ****************************************
  // signature and checksum outputs
  // ****************************************
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_signature <= {`CXB_SIG_W{1'b0}};
      o_checksum <= {`CXB_SUM_W{1'b0}};
    end
    else
    begin
      o_signature <= nv_reg[`CXB_SIG_LSB +: `CXB_SIG_W];
      o_checksum <= sum_w[`CXB_CELLS];
    end
  end
endmodule // cxb_crossbar

// [bench/cxb_chk.sv]
`timescale 1ns/1ps
`include "cxb_defines.vh"
module cxb_chk #(parameter ERASE_CYC = 4, parameter WRITE_CYC = 4) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`CXB_CELLS-1:0] o_pad_oe,
  input wire i_prog_mode,
  input wire o_prog_serial_out,
  input wire o_prog_busy,
  input wire [`CXB_SIG_W-1:0] o_signature,
  input wire [`CXB_SUM_W-1:0] o_checksum
);
  // ****
  // port checks
  // ****
  localparam int LIM = ERASE_CYC + WRITE_CYC + 12;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_busy_hi_z: assert property (o_prog_busy |-> o_pad_oe == 0) else $error("oe while busy");
  a_mode_starts: assert property ($rose(i_prog_mode) && !o_prog_busy |-> ##[1:5] o_prog_busy)
    else $error("no start");
  a_shift_busy: assert property (i_prog_mode && o_prog_busy |=> o_prog_busy) else $error("busy dropped");
  a_erase_hold: assert property ($fell(i_prog_mode) && o_prog_busy |-> o_prog_busy [*4])
    else $error("short erase");
  a_prog_bound: assert property ($fell(i_prog_mode) && o_prog_busy |-> ##[1:LIM] !o_prog_busy)
    else $error("too slow");
  a_sig_keep: assert property (!o_prog_busy && !$past(o_prog_busy) && !$past(o_prog_busy, 2) &&
    $past(i_rst_n, 3) |-> $stable(o_signature)) else $error("sig moved");
  a_sum_follow: assert property ($changed(o_signature) |-> ##[0:1] $changed(o_checksum))
    else $error("sum kept");
  a_sout_idle: assert property (!i_prog_mode && !o_prog_busy && $past(i_rst_n, 2) |=>
    $stable(o_prog_serial_out)) else $error("sout moved");
  c_done: cover property ($fell(o_prog_busy));
  c_drive: cover property (o_pad_oe != 0 && !o_prog_busy);
  c_sig: cover property ($changed(o_signature));
endmodule // cxb_chk
bind cxb_crossbar cxb_chk #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) cxb_chk_inst (.i_mclk, .i_rst_n,
  .o_pad_oe, .i_prog_mode, .o_prog_serial_out, .o_prog_busy, .o_signature, .o_checksum);

// [bench/cxb_prog_model.sv]
`timescale 1ns/1ps
module cxb_prog_model (
  input wire i_mclk,
  input wire i_go,
  input wire [185:0] i_img,
  input wire i_sdo,
  output reg [185:0] o_back = 186'h0,
  output reg o_mode = 1'h0,
  output reg o_sclk = 1'h0,
  output reg o_sdi = 1'h0
);
  // ****
  // serial programmer
  // ****
  integer i;
  task tick(input integer k);
    begin
      repeat (k) @(posedge i_mclk);
      #1;
    end
  endtask
  always @(posedge i_go)
  begin
    o_mode = 1'h1;
    tick(6);
    for (i = 185; i >= 0; i = i - 1)
    begin
      o_sdi = i_img[i];
      tick(3);
      o_back[i] = i_sdo;
      o_sclk = 1'h1;
      tick(3);
      o_sclk = 1'h0;
    end
    tick(6);
    o_sdi = ~o_sdi;
    o_mode = 1'h0;
  end
endmodule // cxb_prog_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  // ****
  // bench
  // ****
  reg i_mclk = 0;
  reg i_rst_n = 0;
  reg go = 0;
  reg [21:0] i_pad_in = 0;
  reg [185:0] img = 0;
  reg [185:0] old_img = 0;
  wire mode, sclk, prog_serial_in, busy, sout;
  wire [185:0] back;
  wire [21:0] oe, out;
  wire [31:0] sig;
  wire [15:0] sum;
  integer num_errors = 0;
  integer tests_run = 0;
  integer n, c;
  initial forever #5 i_mclk = ~i_mclk;
  cxb_crossbar #(.ERASE_CYC(4), .WRITE_CYC(4)) cxb_crossbar_inst (.i_mclk, .i_rst_n, .i_pad_in, .o_pad_out(out),
    .o_pad_oe(oe), .i_prog_mode(mode), .i_prog_sclk(sclk), .i_prog_serial_in(prog_serial_in), .o_prog_serial_out(sout),
    .o_prog_busy(busy), .o_signature(sig), .o_checksum(sum));
  cxb_prog_model cxb_prog_model_inst (.i_mclk, .i_go(go), .i_img(img), .i_sdo(sout), .o_back(back),
    .o_mode(mode), .o_sclk(sclk), .o_sdi(prog_serial_in));
  function [43:0] exp_pads(input [185:0] m, input [21:0] p);
    integer k;
    reg [2:0] f;
    reg [3:0] s;
    reg v;
    begin
      exp_pads = 0;
      for (k = 0; k < 22; k = k + 1)
      begin
        {f, s} = m[7*k +: 7];
        v = s < 11 ? p[s + (k < 11 ? 11 : 0)] : 1'h0;
        exp_pads[22+k] = f < 4;
        exp_pads[k] = f == 3 || (f < 2 && (v ^ f[0]));
      end
    end
  endfunction
  function [15:0] exp_sum(input [185:0] m);
    integer k;
    begin
      exp_sum = m[169:154] + m[185:170];
      for (k = 0; k < 22; k = k + 1)
        exp_sum = exp_sum + m[7*k +: 7];
    end
  endfunction
  function [6:0] rnd_cell();
    reg [2:0] f;
    begin
      f = $urandom_range(7);
      rnd_cell = f == 3'h7 ? 7'h7f : {f, 4'($urandom_range(11))};
    end
  endfunction
  task stop_test;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] name, input [185:0] got, input [185:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("unexpected %s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task wait_busy(input lvl);
    begin
      for (n = 0; n < 3000 && busy !== lvl; n = n + 1)
      begin
        @(posedge i_mclk);
        #1;
      end
      if (n == 3000)
      begin
        num_errors = num_errors + 1;
        stop_test;
      end
    end
  endtask
  task prog(input kind);
    begin
      for (c = 0; c < 22; c = c + 1)
        img[7*c +: 7] = ((c < 11) == kind) ? 7'h40 : rnd_cell();
      img[185:154] = $urandom;
      go = 1;
      wait_busy(1);
      chk("oe", oe, 0);
      go = 0;
      wait_busy(0);
    end
  endtask
  task check_pads;
    begin
      repeat (8)
      begin
        i_pad_in = $urandom;
        repeat (4) @(posedge i_mclk);
        #1;
        chk("oe", oe, exp_pads(img, i_pad_in) >> 22);
        chk("out", out & oe, exp_pads(img, i_pad_in) & 22'h3f_ffff);
      end
      chk("sig", sig, img[185:154]);
      chk("sum", sum, exp_sum(img));
    end
  endtask
  initial
  begin
    n = $urandom(43);
    repeat (8) @(posedge i_mclk);
    #1 i_rst_n = 1;
    prog(1);
    check_pads;
    old_img = img;
    prog(0);
    chk("back", back, old_img);
    check_pads;
    i_rst_n = 0;
    repeat (2) @(posedge i_mclk);
    #1 i_rst_n = 1;
    check_pads;
    stop_test;
  end
endmodule // tb
